// ===== shared/psom_defines.svh
`ifndef PSOM_DEFINES_SVH
`define PSOM_DEFINES_SVH

// command codes of the two status bytes
`define PSOM_CMD_SUPP 8'h7f
`define PSOM_CMD_MFR 8'h80

// supplementary status field
`define PSOM_SUPP_FIRST_BIT 0

// maker-specific status fields
`define PSOM_MFR_POR_BIT 7
`define PSOM_MFR_SELF_BIT 6
`define PSOM_MFR_RESTORE_BIT 3
`define PSOM_MFR_BCX_BIT 2
`define PSOM_MFR_SYNC_BIT 1

// bits that software may clear by writing one
`define PSOM_MFR_W1C_MASK 8'h8e
`define PSOM_SUPP_W1C_MASK 8'h01
// latched bits that feed the summary and the alert
`define PSOM_MFR_LATCH_MASK 8'h8e

// reset values
`define PSOM_SUPP_RESET 8'h00
`define PSOM_MFR_RESET 8'h00
`define PSOM_MASK_RESET 8'h00

`endif

// ===== shared/psom_pkg.sv
package psom_pkg;

  // one host command transaction as seen by the block
  typedef struct packed {
    logic rd;
    logic wr;
    logic clear_all;
    logic [7:0] code;
    logic [7:0] wdata;
  } psom_cmd_s;

  // fault event pulses from the converter logic
  typedef struct packed {
    logic por_fail;
    logic restore;
    logic backchannel_fault;
    logic sync;
  } psom_evt_s;

  // status summary seen by the top-level status byte and alert logic
  typedef struct packed {
    logic supp_summary;
    logic mfr_summary;
    logic alert_req;
  } psom_sum_s;

endpackage : psom_pkg

// ===== src/psom_status.sv
`timescale 1ns/10ps
`include "psom_defines.svh"
// Overview of operation
// [RQ1] read of 7Fh returns supplementary byte
// [RQ2] bit0 latches when we alerted first
// [RQ3] bit0 zero if not first alerter
// [RQ4] summary bit is OR of supported bits
// [RQ5] clearing byte also clears its summary
// [RQ6] 80h readable, cleared by clear-all or W1C
// [RQ7] bit7 latches on power-on check failure
// [RQ8] bit6 live self-check in progress
// [RQ9] bit3 latches on output restore event
// [RQ10] bit2 latches on backchannel fault
// [RQ11] bit1 latches on synchronisation fault
// [RQ12] bits 5:4 read zero, writes ignored
// [RQ13] write one clears only set bits
// [RQ14] each alerting bit has a mask bit
// [RQ15] maker byte has byte read/write access
// [RQ16] writes to read-only bits are ignored
module psom_status
  import psom_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire psom_cmd_s cmd,
  input wire psom_evt_s evt,
  input wire logic self_check_busy,
  input wire logic alert_line_active,
  input wire logic alert_drive_self,
  input wire logic [7:0] mfr_alert_mask,
  input wire logic supp_alert_mask,
  output logic [7:0] rdata,
  output logic rvalid,
  output psom_sum_s summary
);

  logic first_alerter_flag_reg;
  logic [7:0] mfr_reg;
  logic self_live_reg;
  logic alert_prev_reg;
  logic first_set;
  logic supp_clr;
  logic [7:0] mfr_clr;
  logic [7:0] mfr_set;
  logic [7:0] mfr_next;
  logic first_next;

  // we are first when our own drive raises an idle line
  assign first_set = alert_drive_self && !alert_prev_reg;
  // clear-all or write one; only set bits are affected
  assign supp_clr = cmd.clear_all || (cmd.wr && cmd.code == `PSOM_CMD_SUPP &&
                    cmd.wdata[`PSOM_SUPP_FIRST_BIT]); // [RQ13] [RQ16]
  assign mfr_clr = (cmd.clear_all ? `PSOM_MFR_W1C_MASK : 8'h00) |
                   ((cmd.wr && cmd.code == `PSOM_CMD_MFR) ? (cmd.wdata & `PSOM_MFR_W1C_MASK) : 8'h00); // [RQ6] [RQ12]

  // event set vector; set wins over clear in the same cycle
  always_comb begin
    mfr_set = 8'h00;
    mfr_set[`PSOM_MFR_POR_BIT] = evt.por_fail; // [RQ7]
    mfr_set[`PSOM_MFR_RESTORE_BIT] = evt.restore; // [RQ9]
    mfr_set[`PSOM_MFR_BCX_BIT] = evt.backchannel_fault; // [RQ10]
    mfr_set[`PSOM_MFR_SYNC_BIT] = evt.sync; // [RQ11]
    mfr_next = ((mfr_reg & ~mfr_clr) | mfr_set) & `PSOM_MFR_LATCH_MASK; // [RQ12]
    // dropping line also ends the first-alerter claim
    first_next = first_set || (first_alerter_flag_reg && !supp_clr && alert_line_active); // [RQ2] [RQ3]
  end

  // alert line history for first-assert detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alert_prev_reg <= 1'b0;
    end else begin
      alert_prev_reg <= alert_line_active;
    end
  end

  // supplementary flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      first_alerter_flag_reg <= 1'b0;
    end else begin
      first_alerter_flag_reg <= first_next; // [RQ2] [RQ3]
    end
  end

  // maker-specific latched bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mfr_reg <= `PSOM_MFR_RESET;
    end else begin
      mfr_reg <= mfr_next; // [RQ6] [RQ13]
    end
  end

  // live self-check copy, never latched
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      self_live_reg <= 1'b1;
    end else begin
      self_live_reg <= self_check_busy; // [RQ8]
    end
  end

  // read port: one cycle after the read request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= cmd.rd && (cmd.code == `PSOM_CMD_SUPP || cmd.code == `PSOM_CMD_MFR);
      if (cmd.rd && cmd.code == `PSOM_CMD_SUPP) begin
        rdata <= {7'h00, first_alerter_flag_reg}; // [RQ1]
      end else if (cmd.rd && cmd.code == `PSOM_CMD_MFR) begin
        rdata <= mfr_reg | ({7'h00, self_live_reg} << `PSOM_MFR_SELF_BIT); // [RQ15] [RQ8]
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // summaries follow the latched state; masks gate only the alert request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      summary <= '0;
    end else begin
      summary.supp_summary <= first_next; // [RQ4] [RQ5]
      summary.mfr_summary <= |mfr_next; // [RQ4] [RQ5]
      summary.alert_req <= |(mfr_next & ~mfr_alert_mask) || (first_next && !supp_alert_mask); // [RQ14]
    end
  end

  // checks
  property p_por_latch;
    @(posedge core_clk) disable iff (rst)
      evt.por_fail |=> mfr_reg[`PSOM_MFR_POR_BIT];
  endproperty
  a_por_latch: assert property (p_por_latch) else $error("por bit not latched"); // [RQ7]

  property p_sync_hold;
    @(posedge core_clk) disable iff (rst)
      mfr_reg[`PSOM_MFR_SYNC_BIT] && !mfr_clr[`PSOM_MFR_SYNC_BIT] |=> mfr_reg[`PSOM_MFR_SYNC_BIT];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync bit lost"); // [RQ11]

  property p_w1c;
    @(posedge core_clk) disable iff (rst)
      cmd.wr && cmd.code == `PSOM_CMD_MFR && cmd.wdata[`PSOM_MFR_BCX_BIT] && !evt.backchannel_fault
      |=> !mfr_reg[`PSOM_MFR_BCX_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("bcx not cleared"); // [RQ13]

  property p_unsup_zero;
    @(posedge core_clk) disable iff (rst)
      rvalid |-> rdata[5:4] == 2'b00;
  endproperty
  a_unsup_zero: assert property (p_unsup_zero) else $error("bits 5:4 nonzero"); // [RQ12]

  property p_self_live;
    @(posedge core_clk) disable iff (rst)
      cmd.rd && cmd.code == `PSOM_CMD_MFR |=> rdata[`PSOM_MFR_SELF_BIT] == $past(self_live_reg);
  endproperty
  a_self_live: assert property (p_self_live) else $error("self bit mismatch"); // [RQ8]

  property p_supp_read;
    @(posedge core_clk) disable iff (rst)
      cmd.rd && cmd.code == `PSOM_CMD_SUPP |=> rvalid && rdata[7:1] == 7'h00;
  endproperty
  a_supp_read: assert property (p_supp_read) else $error("supp read wrong"); // [RQ1]

  property p_first;
    @(posedge core_clk) disable iff (rst)
      alert_drive_self && !alert_prev_reg |=> first_alerter_flag_reg && summary.supp_summary;
  endproperty
  a_first: assert property (p_first) else $error("first alerter not set"); // [RQ2]

  property p_not_first;
    @(posedge core_clk) disable iff (rst)
      !alert_line_active && !first_set |=> !first_alerter_flag_reg;
  endproperty
  a_not_first: assert property (p_not_first) else $error("flag set while idle"); // [RQ3]

  property p_summary;
    @(posedge core_clk) disable iff (rst)
      ##1 summary.mfr_summary == |mfr_reg;
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch"); // [RQ4]

  property p_clear_all;
    @(posedge core_clk) disable iff (rst)
      cmd.clear_all && evt == '0 |=> mfr_reg == 8'h00 && !summary.mfr_summary;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear-all failed"); // [RQ6] [RQ5]

  // each fault event lands in its own bit at the next edge, whatever clear comes with it
  property p_restore_latch;
    @(posedge core_clk) disable iff (rst)
      evt.restore
      |=> mfr_reg[`PSOM_MFR_RESTORE_BIT];
  endproperty
  a_restore_latch: assert property (p_restore_latch) else $error("restore bit not latched"); // [RQ9]

  property p_bcx_latch;
    @(posedge core_clk) disable iff (rst)
      evt.backchannel_fault
      |=> mfr_reg[`PSOM_MFR_BCX_BIT];
  endproperty
  a_bcx_latch: assert property (p_bcx_latch) else $error("backchannel bit not latched"); // [RQ10]

  property p_sync_latch;
    @(posedge core_clk) disable iff (rst)
      evt.sync
      |=> mfr_reg[`PSOM_MFR_SYNC_BIT];
  endproperty
  a_sync_latch: assert property (p_sync_latch) else $error("sync bit not latched"); // [RQ11]

  // write one on the top bit drops it when no new failure arrives
  property p_por_w1c;
    @(posedge core_clk) disable iff (rst)
      cmd.wr && cmd.code == `PSOM_CMD_MFR && cmd.wdata[`PSOM_MFR_POR_BIT] && !evt.por_fail
      |=> !mfr_reg[`PSOM_MFR_POR_BIT];
  endproperty
  a_por_w1c: assert property (p_por_w1c) else $error("por bit not cleared"); // [RQ13]

  // read answers carry the state seen at the request edge
  property p_mfr_read;
    @(posedge core_clk) disable iff (rst)
      cmd.rd && cmd.code == `PSOM_CMD_MFR
      |=> rvalid && (rdata & `PSOM_MFR_W1C_MASK) == $past(mfr_reg);
  endproperty
  a_mfr_read: assert property (p_mfr_read) else $error("maker byte read wrong"); // [RQ6] [RQ15]

  property p_supp_data;
    @(posedge core_clk) disable iff (rst)
      cmd.rd && cmd.code == `PSOM_CMD_SUPP
      |=> rdata[`PSOM_SUPP_FIRST_BIT] == $past(first_alerter_flag_reg);
  endproperty
  a_supp_data: assert property (p_supp_data) else $error("first alerter read wrong"); // [RQ1]

  // other codes get no answer, and idle read data stays quiet
  property p_no_answer;
    @(posedge core_clk) disable iff (rst)
      !(cmd.rd && (cmd.code == `PSOM_CMD_SUPP || cmd.code == `PSOM_CMD_MFR))
      |=> !rvalid && rdata == 8'h00;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("unexpected read answer"); // [RQ15]

  property p_latched_only;
    @(posedge core_clk) disable iff (rst)
      (mfr_reg & ~`PSOM_MFR_LATCH_MASK) == 8'h00;
  endproperty
  a_latched_only: assert property (p_latched_only) else $error("unsupported bit latched"); // [RQ12]

  // writes with no clearing ones leave every latch alone
  property p_supp_ro_write;
    @(posedge core_clk) disable iff (rst)
      cmd.wr && cmd.code == `PSOM_CMD_SUPP && !cmd.wdata[`PSOM_SUPP_FIRST_BIT] && !cmd.clear_all
      && first_alerter_flag_reg && alert_line_active
      |=> first_alerter_flag_reg;
  endproperty
  a_supp_ro_write: assert property (p_supp_ro_write) else $error("reserved write disturbed flag"); // [RQ16]

  property p_mfr_ro_write;
    @(posedge core_clk) disable iff (rst)
      cmd.wr && cmd.code == `PSOM_CMD_MFR && (cmd.wdata & `PSOM_MFR_W1C_MASK) == 8'h00
      && !cmd.clear_all && evt == '0
      |=> mfr_reg == $past(mfr_reg);
  endproperty
  a_mfr_ro_write: assert property (p_mfr_ro_write) else $error("read-only write disturbed latches"); // [RQ16]

  property p_first_hold;
    @(posedge core_clk) disable iff (rst)
      first_alerter_flag_reg && alert_line_active && !supp_clr
      |=> first_alerter_flag_reg && summary.supp_summary;
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("first alerter claim lost"); // [RQ2]

  // clearing the flag takes its summary down in the same edge
  property p_supp_w1c;
    @(posedge core_clk) disable iff (rst)
      cmd.wr && cmd.code == `PSOM_CMD_SUPP && cmd.wdata[`PSOM_SUPP_FIRST_BIT] && !first_set
      |=> !first_alerter_flag_reg && !summary.supp_summary;
  endproperty
  a_supp_w1c: assert property (p_supp_w1c) else $error("first alerter not cleared"); // [RQ5]

  property p_clear_all_supp;
    @(posedge core_clk) disable iff (rst)
      cmd.clear_all && !first_set
      |=> !first_alerter_flag_reg && !summary.supp_summary;
  endproperty
  a_clear_all_supp: assert property (p_clear_all_supp) else $error("clear-all kept flag"); // [RQ6]

  // masks are sampled one edge ahead of the registered request
  property p_alert_req;
    @(posedge core_clk) disable iff (rst)
      ##1 summary.alert_req ==
      (|(mfr_reg & ~$past(mfr_alert_mask)) || (first_alerter_flag_reg && !$past(supp_alert_mask)));
  endproperty
  a_alert_req: assert property (p_alert_req) else $error("alert request mismatch"); // [RQ14]

  property p_mfr_summary;
    @(posedge core_clk) disable iff (rst)
      evt != '0
      |=> summary.mfr_summary;
  endproperty
  a_mfr_summary: assert property (p_mfr_summary) else $error("summary not raised"); // [RQ4]

endmodule : psom_status

// ===== tb/psom_host.sv
`timescale 1ns/10ps
// host end of the status bytes: byte read, byte write and global clear
module psom_host
  import psom_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output psom_cmd_s cmd
);
  initial cmd = '0;
  // one request per call, held for one edge; idle fields show inverted leftovers
  task automatic xfer(input logic r, input logic w, input logic c, input logic [7:0] code,
    input logic [7:0] wd, output logic [7:0] d, output logic v);
    @(posedge core_clk);
    cmd <= '{rd: r, wr: w, clear_all: c, code: code, wdata: wd}; // ones in wd clear set bits
    @(posedge core_clk);
    cmd <= '{rd: 1'b0, wr: 1'b0, clear_all: 1'b0, code: ~code, wdata: ~wd};
    #1;
    d = rdata;
    v = rvalid;
  endtask : xfer
endmodule : psom_host

// ===== tb/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("ERROR %0t got %h want %h", $time, g, e); \
  end \
end
module tb;
  import psom_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  psom_cmd_s cmd;
  psom_evt_s evt = '0;
  logic busy = 1'b1;
  logic line_act = 1'b0;
  logic drive_self = 1'b0;
  logic [7:0] mfr_mask = 8'h00;
  logic supp_mask = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  psom_sum_s summary;
  logic [7:0] d;
  logic v;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  psom_status i_dut (.core_clk(core_clk), .rst(rst), .cmd(cmd), .evt(evt), .self_check_busy(busy),
    .alert_line_active(line_act), .alert_drive_self(drive_self), .mfr_alert_mask(mfr_mask),
    .supp_alert_mask(supp_mask), .rdata(rdata), .rvalid(rvalid), .summary(summary));
  psom_host i_host (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid), .cmd(cmd));
  // free-running 100 MHz clock
  initial forever #5 core_clk = ~core_clk;
  task automatic rd(input logic [7:0] code);
    i_host.xfer(1'b1, 1'b0, 1'b0, code, 8'h00, d, v);
  endtask : rd
  task automatic wr(input logic [7:0] code, input logic [7:0] wd);
    i_host.xfer(1'b0, 1'b1, 1'b0, code, wd, d, v);
  endtask : wr
  // summaries change on the same edge as the latched state
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  // our drive raises the idle line one edge ahead of the wired line
  task automatic claim;
    @(posedge core_clk);
    drive_self <= 1'b1;
    @(posedge core_clk);
    line_act <= 1'b1;
    settle();
  endtask : claim
  task automatic t_reset;
    rd(8'h80);
    `CHK(v, 1'b1)
    `CHK(d, 8'h40)
    rd(8'h7f);
    `CHK(d, 8'h00)
    `CHK(summary, 3'b000)
    @(posedge core_clk);
    busy <= 1'b0;
    rd(8'h80);
    `CHK(d, 8'h00)
    rd(8'h7e);
    `CHK(v, 1'b0)
    $display("reset test done");
  endtask : t_reset
  task automatic t_events;
    int pos;
    for (int i = 0; i < 4; i++) begin
      pos = (i == 3) ? 7 : i + 1;
      @(posedge core_clk);
      evt <= 4'(1 << i);
      @(posedge core_clk);
      evt <= '0;
      settle();
      rd(8'h80);
      `CHK(d, 8'(1 << pos))
      `CHK(summary.mfr_summary, 1'b1)
      `CHK(summary.alert_req, 1'b1)
      @(posedge core_clk);
      mfr_mask <= 8'(1 << pos);
      settle();
      `CHK(summary.alert_req, 1'b0)
      @(posedge core_clk);
      mfr_mask <= 8'h00;
      wr(8'h80, 8'h71);
      rd(8'h80);
      `CHK(d, 8'(1 << pos))
      wr(8'h80, 8'(1 << pos));
      settle();
      `CHK(summary.mfr_summary, 1'b0)
      rd(8'h80);
      `CHK(d, 8'h00)
    end
    $display("event test done");
  endtask : t_events
  task automatic t_clr_all;
    @(posedge core_clk);
    evt <= 4'hf;
    @(posedge core_clk);
    evt <= '0;
    settle();
    rd(8'h80);
    `CHK(d, 8'h8e)
    i_host.xfer(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, d, v);
    rd(8'h80);
    `CHK(d, 8'h00)
    @(posedge core_clk);
    evt <= 4'h8;
    @(posedge core_clk);
    evt <= '0;
    // clear-all plus write in the cycle of a sync event: the event survives
    fork
      i_host.xfer(1'b0, 1'b1, 1'b1, 8'h80, 8'h8e, d, v);
      begin
        @(posedge core_clk);
        evt <= 4'h1;
        @(posedge core_clk);
        evt <= '0;
      end
    join
    rd(8'h80);
    `CHK(d, 8'h02)
    wr(8'h80, 8'h02);
    rd(8'h80);
    `CHK(d, 8'h00)
    $display("clear test done");
  endtask : t_clr_all
  task automatic t_first;
    claim();
    rd(8'h7f);
    `CHK(d, 8'h01)
    `CHK(summary.supp_summary, 1'b1)
    `CHK(summary.alert_req, 1'b1)
    @(posedge core_clk);
    supp_mask <= 1'b1;
    settle();
    `CHK(summary.alert_req, 1'b0)
    @(posedge core_clk);
    supp_mask <= 1'b0;
    wr(8'h7f, 8'hfe);
    rd(8'h7f);
    `CHK(d, 8'h01)
    // the line goes idle and the claim goes with it
    @(posedge core_clk);
    line_act <= 1'b0;
    drive_self <= 1'b0;
    settle();
    rd(8'h7f);
    `CHK(d, 8'h00)
    claim();
    wr(8'h7f, 8'h01);
    settle();
    `CHK(summary.supp_summary, 1'b0)
    rd(8'h7f);
    `CHK(d, 8'h00)
    // another device pulls the line first, then we join
    @(posedge core_clk);
    line_act <= 1'b0;
    drive_self <= 1'b0;
    @(posedge core_clk);
    line_act <= 1'b1;
    @(posedge core_clk);
    drive_self <= 1'b1;
    settle();
    rd(8'h7f);
    `CHK(d, 8'h00)
    $display("first alerter test done");
  endtask : t_first
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_clr_all();
    t_first();
    wrap_up();
  end
endmodule : tb
